// ---- hdl/caw_watchdog.sv ----
// Counter array core with module 4 as watchdog, plus the array control register.
// Assumes a single-cycle register port synchronous to CLK and an external
// reset controller that takes WD_RESET and returns RST.
`timescale 1ns/1ns

// Notes on behaviour
// - Module 4 becomes watchdog when enabled
// - Reset leaves watchdog on, divide 12, 256
// - Enabled watchdog keeps counter running except in idle suspend
// - Counter byte writes ignored while enabled
// - Timebase and idle bits frozen while enabled
// - Module 4 forced compare, mode writes ignored
// - Run bit writes cannot stop counter while enabled
// - Run bit reads back only software value
// - Update write loads high byte plus offset
// - Low overflow with high match resets
// - Writing module 4 flag forces reset
// - Timeout is 256*offset plus 256-low
// - Enable or lock bit enables watchdog
// - Lock holds until reset; else enable clears
// - Bit 7 sets on 16-bit rollover
// - Bit 6 runs or stops the counter
// - Bits 4..0 set by module match
// - Control bit 5 reads zero
// - Timebase select picks clock source
// - Enabled watchdog locks other mode bits
// - Idle suspend pauses counting in idle
module caw_watchdog
  import caw_pkg::*;
(
  input wire logic CLK,
  input wire logic RST,
  input wire logic CE,
  input wire logic [7:0] SFR_ADDR,
  input wire logic SFR_WR,
  input wire logic [7:0] SFR_WDATA,
  input wire logic SFR_RD,
  output logic [7:0] SFR_RDATA,
  input wire logic CPU_IDLE,
  input wire logic TIMER0_OVF,
  input wire logic EXTERNAL_COUNT_INPUT,
  input wire logic EXT_CLK_IN,
  input wire logic [3:0] MODULE_MATCH,
  output logic WD_RESET,
  output logic ARRAY_IRQ
);

  // ********************************************************************
  // State
  // ********************************************************************
  typedef struct packed {
    logic ovf_flag;
    logic run;
    logic [4:0] match_flag;
    logic idle_susp;
    logic wd_en_bit;
    logic wd_lock;
    logic [2:0] tb_sel;
    logic ovf_irq_en;
    logic [7:0] m4_mode;
    logic [15:0] count;
    logic [7:0] wd_offset;
    logic [7:0] wd_update;
    logic [7:0] rdata;
    logic wd_reset;
    logic irq;
  } caw_state_t;

  caw_state_t s_ff;
  caw_state_t nxt_s;

  logic wd_active;
  logic counting;
  logic tick;
  logic low_ovf;
  logic full_ovf;
  logic [7:0] m4_eff;

  caw_tick_if tb_if ();

  // Register hit for a write strobe at the given address.
  function automatic logic wr_hit(input logic wr, input logic [7:0] addr,
                                  input logic [7:0] target);
    wr_hit = wr && (addr == target);
  endfunction : wr_hit

  // ********************************************************************
  // Timebase
  // ********************************************************************
  assign wd_active = s_ff.wd_en_bit | s_ff.wd_lock;
  // Counting is forced on by the watchdog, paused only by idle suspend.
  assign counting = (s_ff.run | wd_active) &
                    ~(s_ff.idle_susp & CPU_IDLE);
  assign tb_if.sel = s_ff.tb_sel;
  assign tb_if.go = counting;

  caw_timebase u_timebase (
    .clk(CLK),
    .rst(RST),
    .ce(CE),
    .timer0_ovf(TIMER0_OVF),
    .external_count_input(EXTERNAL_COUNT_INPUT),
    .ext_clk_in(EXT_CLK_IN),
    .tb(tb_if.gen)
  );

  // The tick is registered one cycle late, so it is gated again here to
  // avoid a stray count just after the counter was stopped.
  assign tick = tb_if.tick & counting;
  assign low_ovf = tick && (s_ff.count[7:0] == LOW_BYTE_MAX);
  assign full_ovf = tick && (s_ff.count == COUNTER_MAX);
  assign m4_eff = wd_active ? M4_FORCED_MODE : s_ff.m4_mode;

  // ********************************************************************
  // Next state
  // ********************************************************************
  always_comb begin
    nxt_s = s_ff;
    nxt_s.wd_reset = 1'b0;

    if (tick) begin
      nxt_s.count = s_ff.count + 16'h0001;
    end

    // Control register; software writes may set or clear every flag.
    if (wr_hit(SFR_WR, SFR_ADDR, ADDR_ARRAY_CONTROL)) begin
      nxt_s.ovf_flag = SFR_WDATA[CTRL_OVF_BIT];
      nxt_s.run = SFR_WDATA[CTRL_RUN_BIT];
      nxt_s.match_flag = SFR_WDATA[4:0];
      if (wd_active && SFR_WDATA[CTRL_M4_FLAG_BIT]) begin
        nxt_s.wd_reset = 1'b1;
      end
    end

    if (wr_hit(SFR_WR, SFR_ADDR, ADDR_ARRAY_MODE)) begin
      if (wd_active) begin
        // Only the enable and lock bits may change; the lock can be added but not removed.
        nxt_s.wd_en_bit = SFR_WDATA[MODE_WDEN_BIT];
        nxt_s.wd_lock = s_ff.wd_lock | SFR_WDATA[MODE_LOCK_BIT];
      end else begin
        nxt_s.idle_susp = SFR_WDATA[MODE_IDLE_BIT];
        nxt_s.wd_en_bit = SFR_WDATA[MODE_WDEN_BIT];
        nxt_s.wd_lock = SFR_WDATA[MODE_LOCK_BIT];
        nxt_s.tb_sel = SFR_WDATA[MODE_TB_MSB:MODE_TB_LSB];
        nxt_s.ovf_irq_en = SFR_WDATA[MODE_IRQEN_BIT];
      end
    end

    if (wr_hit(SFR_WR, SFR_ADDR, ADDR_MODULE4_MODE) && !wd_active) begin
      nxt_s.m4_mode = SFR_WDATA;
    end

    // A software counter write beats a tick in the same cycle.
    if (wr_hit(SFR_WR, SFR_ADDR, ADDR_COUNTER_LOW) && !wd_active) begin
      nxt_s.count[7:0] = SFR_WDATA;
    end
    if (wr_hit(SFR_WR, SFR_ADDR, ADDR_COUNTER_HIGH) && !wd_active) begin
      nxt_s.count[15:8] = SFR_WDATA;
    end

    if (wr_hit(SFR_WR, SFR_ADDR, ADDR_WD_OFFSET)) begin
      nxt_s.wd_offset = SFR_WDATA;
      if (!wd_active) begin
        nxt_s.m4_mode[M4_ECOM_BIT] = 1'b0;
      end
    end

    if (wr_hit(SFR_WR, SFR_ADDR, ADDR_WD_UPDATE)) begin
      if (wd_active) begin
        // The written value is discarded; the deadline moves instead.
        nxt_s.wd_update = s_ff.count[15:8] + s_ff.wd_offset;
      end else begin
        nxt_s.wd_update = SFR_WDATA;
        nxt_s.m4_mode[M4_ECOM_BIT] = 1'b1;
      end
    end

    // Hardware sets come last so an event beats a clear in the same cycle.
    if (full_ovf) begin
      nxt_s.ovf_flag = 1'b1;
    end
    nxt_s.match_flag[3:0] = nxt_s.match_flag[3:0] | MODULE_MATCH;
    if (!wd_active && tick && m4_eff[M4_ECOM_BIT] && m4_eff[M4_MAT_BIT] &&
        (s_ff.count == {s_ff.wd_update, s_ff.wd_offset})) begin
      nxt_s.match_flag[4] = 1'b1;
    end

    if (wd_active && low_ovf && (s_ff.wd_update == s_ff.count[15:8])) begin
      nxt_s.wd_reset = 1'b1;
    end

    nxt_s.irq = (nxt_s.ovf_flag & nxt_s.ovf_irq_en) |
                (nxt_s.match_flag[4] & m4_eff[M4_IRQEN_BIT]);

    // ******************************************************************
    // Read data, captured from the state before any same-cycle write
    // ******************************************************************
    if (SFR_RD) begin
      case (SFR_ADDR)
        ADDR_ARRAY_CONTROL: begin
          nxt_s.rdata = {s_ff.ovf_flag, s_ff.run, 1'b0, s_ff.match_flag};
        end
        ADDR_ARRAY_MODE: begin
          nxt_s.rdata = {s_ff.idle_susp, s_ff.wd_en_bit, s_ff.wd_lock, 1'b0,
                         s_ff.tb_sel, s_ff.ovf_irq_en};
        end
        ADDR_MODULE4_MODE: begin
          nxt_s.rdata = m4_eff;
        end
        ADDR_COUNTER_LOW: begin
          nxt_s.rdata = s_ff.count[7:0];
        end
        ADDR_COUNTER_HIGH: begin
          nxt_s.rdata = s_ff.count[15:8];
        end
        ADDR_WD_OFFSET: begin
          nxt_s.rdata = s_ff.wd_offset;
        end
        ADDR_WD_UPDATE: begin
          nxt_s.rdata = s_ff.wd_update;
        end
        default: begin
          nxt_s.rdata = 8'h00;
        end
      endcase
    end

    if (!CE) begin
      nxt_s = s_ff;
    end
  end

  // ********************************************************************
  // Registers
  // ********************************************************************
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      s_ff.ovf_flag <= CTRL_RESET[CTRL_OVF_BIT];
      s_ff.run <= CTRL_RESET[CTRL_RUN_BIT];
      s_ff.match_flag <= CTRL_RESET[4:0];
      s_ff.idle_susp <= MODE_RESET[MODE_IDLE_BIT];
      s_ff.wd_en_bit <= MODE_RESET[MODE_WDEN_BIT];
      s_ff.wd_lock <= MODE_RESET[MODE_LOCK_BIT];
      s_ff.tb_sel <= MODE_RESET[MODE_TB_MSB:MODE_TB_LSB];
      s_ff.ovf_irq_en <= MODE_RESET[MODE_IRQEN_BIT];
      s_ff.m4_mode <= M4_MODE_RESET;
      s_ff.count <= COUNTER_RESET;
      s_ff.wd_offset <= WD_OFFSET_RESET;
      s_ff.wd_update <= WD_UPDATE_RESET;
      s_ff.rdata <= 8'h00;
      s_ff.wd_reset <= 1'b0;
      s_ff.irq <= 1'b0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign SFR_RDATA = s_ff.rdata;
  assign WD_RESET = s_ff.wd_reset;
  assign ARRAY_IRQ = s_ff.irq;

endmodule : caw_watchdog

// ---- include/caw_pkg.sv ----
// Constants shared by the counter array watchdog block and its timebase generator.
// Assumes an 8-bit special-function-register port addressed by byte.
package caw_pkg;

  // ********************************************************************
  // Register addresses
  // ********************************************************************
  localparam logic [7:0] ADDR_ARRAY_CONTROL = 8'hd8;
  localparam logic [7:0] ADDR_ARRAY_MODE = 8'hd9;
  localparam logic [7:0] ADDR_MODULE4_MODE = 8'hde;
  localparam logic [7:0] ADDR_COUNTER_LOW = 8'hf9;
  localparam logic [7:0] ADDR_COUNTER_HIGH = 8'hfa;
  localparam logic [7:0] ADDR_WD_OFFSET = 8'hfb;
  localparam logic [7:0] ADDR_WD_UPDATE = 8'hfc;

  // ********************************************************************
  // Field positions
  // ********************************************************************
  localparam int CTRL_OVF_BIT = 7;
  localparam int CTRL_RUN_BIT = 6;
  localparam int CTRL_M4_FLAG_BIT = 4;
  localparam int MODE_IDLE_BIT = 7;
  localparam int MODE_WDEN_BIT = 6;
  localparam int MODE_LOCK_BIT = 5;
  localparam int MODE_TB_LSB = 1;
  localparam int MODE_TB_MSB = 3;
  localparam int MODE_IRQEN_BIT = 0;
  localparam int M4_ECOM_BIT = 6;
  localparam int M4_MAT_BIT = 3;
  localparam int M4_IRQEN_BIT = 0;

  // ********************************************************************
  // Reset values and fixed encodings
  // ********************************************************************
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] MODE_RESET = 8'h40;
  localparam logic [7:0] M4_MODE_RESET = 8'h00;
  localparam logic [15:0] COUNTER_RESET = 16'h0000;
  localparam logic [7:0] WD_OFFSET_RESET = 8'h00;
  localparam logic [7:0] WD_UPDATE_RESET = 8'h00;
  localparam logic [7:0] M4_FORCED_MODE = 8'h48;
  localparam logic [7:0] LOW_BYTE_MAX = 8'hff;
  localparam logic [15:0] COUNTER_MAX = 16'hffff;

  // ********************************************************************
  // Timebase
  // ********************************************************************
  typedef enum logic [2:0] {
    TB_DIV12 = 3'b000,
    TB_DIV4 = 3'b001,
    TB_TIMER0 = 3'b010,
    TB_EXT_FALL = 3'b011,
    TB_SYSCLK = 3'b100,
    TB_EXTCLK_DIV8 = 3'b101
  } caw_timebase_t;

  localparam logic [3:0] DIV12_COUNT = 4'hc;
  localparam logic [3:0] DIV4_COUNT = 4'h4;
  localparam logic [3:0] EXT_DIV_COUNT = 4'h8;
  localparam logic [3:0] SINGLE_COUNT = 4'h1;

endpackage : caw_pkg

// ---- include/caw_tick_if.sv ----
// Carrier between the watchdog core and its timebase generator.
// Assumes both ends run on the same clock.
`timescale 1ns/1ns
interface caw_tick_if;
  logic [2:0] sel;
  logic go;
  logic tick;
  modport ctrl (output sel, output go, input tick);
  modport gen (input sel, input go, output tick);
endinterface : caw_tick_if

// ---- hdl/caw_timebase.sv ----
// Timebase generator: turns the selected source into one-cycle count ticks.
// Assumes all source inputs are synchronous to the system clock.
`timescale 1ns/1ns
module caw_timebase
  import caw_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic timer0_ovf,
  input wire logic external_count_input,
  input wire logic ext_clk_in,
  caw_tick_if.gen tb
);

  typedef struct packed {
    logic [3:0] div;
    logic ext_in_q;
    logic ext_clk_q;
    logic tick;
  } caw_tb_state_t;

  caw_tb_state_t s_ff;
  caw_tb_state_t nxt_s;
  logic ev;
  logic [3:0] lim;

  assign tb.tick = s_ff.tick;

  always_comb begin
    nxt_s = s_ff;
    nxt_s.tick = 1'b0;
    nxt_s.ext_in_q = external_count_input;
    nxt_s.ext_clk_q = ext_clk_in;
    ev = 1'b1;
    lim = SINGLE_COUNT;
    case (tb.sel)
      TB_DIV12: begin
        lim = DIV12_COUNT;
      end
      TB_DIV4: begin
        lim = DIV4_COUNT;
      end
      TB_TIMER0: begin
        ev = timer0_ovf;
      end
      TB_EXT_FALL: begin
        ev = s_ff.ext_in_q & ~external_count_input;
      end
      TB_SYSCLK: begin
        lim = SINGLE_COUNT;
      end
      TB_EXTCLK_DIV8: begin
        ev = ~s_ff.ext_clk_q & ext_clk_in;
        lim = EXT_DIV_COUNT;
      end
      default: begin
        // Reserved selections give no ticks at all.
        ev = 1'b0;
      end
    endcase
    if (tb.go && ev) begin
      // The compare is >= so a switch to a shorter divider never overshoots.
      if (s_ff.div >= lim - SINGLE_COUNT) begin
        nxt_s.div = 4'h0;
        nxt_s.tick = 1'b1;
      end else begin
        nxt_s.div = s_ff.div + SINGLE_COUNT;
      end
    end
    if (!ce) begin
      nxt_s = s_ff;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      // The clock edge detector starts high so that a pin idling high gives
      // no false rising edge just after reset.
      s_ff <= '{div: 4'h0, ext_in_q: 1'b0, ext_clk_q: 1'b1, tick: 1'b0};
    end else begin
      s_ff <= nxt_s;
    end
  end

endmodule : caw_timebase

// ---- test/caw_watchdog_asserts.sv ----
// Port-level checks for the counter array watchdog.
// Assumes it is bound to caw_watchdog and runs on its single clock.
`timescale 1ns/1ns
module caw_watchdog_asserts
  import caw_pkg::*;
(
  input wire logic CLK,
  input wire logic RST,
  input wire logic CE,
  input wire logic [7:0] SFR_ADDR,
  input wire logic SFR_WR,
  input wire logic [7:0] SFR_WDATA,
  input wire logic SFR_RD,
  input wire logic [7:0] SFR_RDATA,
  input wire logic CPU_IDLE,
  input wire logic TIMER0_OVF,
  input wire logic EXTERNAL_COUNT_INPUT,
  input wire logic EXT_CLK_IN,
  input wire logic [3:0] MODULE_MATCH,
  input wire logic WD_RESET,
  input wire logic ARRAY_IRQ
);
  // Shadow of the mode register and the software run bit, kept from bus writes.
  logic [7:0] mode_ff;
  logic run_ff;
  logic wd_on;
  logic wr_ok;
  logic rd_ok;
  assign wd_on = mode_ff[MODE_WDEN_BIT] | mode_ff[MODE_LOCK_BIT];
  assign wr_ok = CE && SFR_WR;
  assign rd_ok = CE && SFR_RD;
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      mode_ff <= MODE_RESET;
      run_ff <= 1'b0;
    end else begin
      if (wr_ok && SFR_ADDR == ADDR_ARRAY_MODE && wd_on) begin
        mode_ff <= {mode_ff[7], SFR_WDATA[6], mode_ff[5] | SFR_WDATA[5], mode_ff[4:0]};
      end else if (wr_ok && SFR_ADDR == ADDR_ARRAY_MODE) begin
        mode_ff <= SFR_WDATA & 8'hef;
      end
      if (wr_ok && SFR_ADDR == ADDR_ARRAY_CONTROL) begin
        run_ff <= SFR_WDATA[CTRL_RUN_BIT];
      end
    end
  end

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RST);

  // ********************************************************************
  // Assertions
  // ********************************************************************
  a_wd_pulse_one: assert property (WD_RESET |=> !WD_RESET)
    else $error("watchdog reset longer than one cycle");
  a_force_reset: assert property (wr_ok && SFR_ADDR == ADDR_ARRAY_CONTROL
    && SFR_WDATA[CTRL_M4_FLAG_BIT] && wd_on |=> WD_RESET)
    else $error("forced watchdog reset missing");
  a_off_no_reset: assert property (!wd_on [*3] |-> !WD_RESET)
    else $error("watchdog reset while disabled");
  a_mode_readback: assert property (rd_ok && SFR_ADDR == ADDR_ARRAY_MODE
    |=> SFR_RDATA == $past(mode_ff))
    else $error("mode register readback wrong");
  a_m4_forced: assert property (rd_ok && SFR_ADDR == ADDR_MODULE4_MODE && wd_on
    |=> SFR_RDATA == M4_FORCED_MODE)
    else $error("module 4 mode not forced");
  a_ctrl_unused: assert property (rd_ok && SFR_ADDR == ADDR_ARRAY_CONTROL
    |=> SFR_RDATA[5] == 1'b0)
    else $error("control bit 5 not zero");
  a_run_readback: assert property (rd_ok && SFR_ADDR == ADDR_ARRAY_CONTROL
    |=> SFR_RDATA[CTRL_RUN_BIT] == $past(run_ff))
    else $error("run bit readback wrong");
  a_quiet_start: assert property ($fell(RST) |-> !WD_RESET [*8])
    else $error("watchdog reset right after reset");

  c_force: cover property (wr_ok && SFR_ADDR == ADDR_ARRAY_CONTROL && SFR_WDATA[4] && wd_on);
  c_timeout: cover property (WD_RESET && !$past(wr_ok));
  c_lock: cover property (mode_ff[MODE_LOCK_BIT] && !mode_ff[MODE_WDEN_BIT]);
endmodule : caw_watchdog_asserts

bind caw_watchdog caw_watchdog_asserts u_chk (
  .CLK(CLK), .RST(RST), .CE(CE), .SFR_ADDR(SFR_ADDR), .SFR_WR(SFR_WR),
  .SFR_WDATA(SFR_WDATA), .SFR_RD(SFR_RD), .SFR_RDATA(SFR_RDATA), .CPU_IDLE(CPU_IDLE),
  .TIMER0_OVF(TIMER0_OVF), .EXTERNAL_COUNT_INPUT(EXTERNAL_COUNT_INPUT),
  .EXT_CLK_IN(EXT_CLK_IN), .MODULE_MATCH(MODULE_MATCH), .WD_RESET(WD_RESET),
  .ARRAY_IRQ(ARRAY_IRQ)
);

// ---- test/testbench.sv ----
// Self-checking bench for the counter array watchdog.
// Assumes the bench plays both the CPU and the reset controller.
`timescale 1ns/1ns
module testbench;
  import caw_pkg::*;
  logic CLK, RST, SFR_WR, SFR_RD, WD_RESET, ARRAY_IRQ;
  logic CE;
  logic CPU_IDLE;
  logic [7:0] SFR_ADDR, SFR_WDATA, SFR_RDATA;
  logic [3:0] MODULE_MATCH;
  int miscompares;
  int checked;
  caw_watchdog DUT (
    .CLK(CLK), .RST(RST), .CE(CE), .SFR_ADDR(SFR_ADDR), .SFR_WR(SFR_WR),
    .SFR_WDATA(SFR_WDATA), .SFR_RD(SFR_RD), .SFR_RDATA(SFR_RDATA), .CPU_IDLE(CPU_IDLE),
    .TIMER0_OVF(1'b0), .EXTERNAL_COUNT_INPUT(1'b0), .EXT_CLK_IN(1'b0),
    .MODULE_MATCH(MODULE_MATCH), .WD_RESET(WD_RESET), .ARRAY_IRQ(ARRAY_IRQ)
  );
  initial begin
    CLK = 1'b0;
    forever #10 CLK = ~CLK;
  end

  // ********************************************************************
  // Bus and check helpers
  // ********************************************************************
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic summarize();
    if (miscompares == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : summarize
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge CLK);
    SFR_ADDR = a;
    SFR_WDATA = d;
    SFR_WR = 1'b1;
    @(negedge CLK);
    SFR_WR = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge CLK);
    SFR_ADDR = a;
    SFR_RD = 1'b1;
    @(negedge CLK);
    SFR_RD = 1'b0;
    d = SFR_RDATA;
  endtask : rd
  task automatic rdc(input string what, input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] v;
    rd(a, v);
    chk(what, v, exp);
  endtask : rdc
  // A reset that never comes is a failure, so the wait ends the run.
  task automatic wait_wd(input int lim, output int cyc);
    cyc = 0;
    while (WD_RESET !== 1'b1 && cyc < lim) begin
      @(negedge CLK);
      cyc++;
    end
    if (WD_RESET !== 1'b1) begin
      chk("wd pulse", 8'h00, 8'h01);
      summarize();
    end
  endtask : wait_wd
  task automatic do_reset(input int n);
    RST = 1'b1;
    repeat (n) @(negedge CLK);
    RST = 1'b0;
  endtask : do_reset

  // ********************************************************************
  // Scenarios
  // ********************************************************************
  task automatic t_defaults();
    int c;
    do_reset(12);
    rdc("low", ADDR_COUNTER_LOW, 8'h00);
    rdc("mode", ADDR_ARRAY_MODE, MODE_RESET);
    rdc("ctrl", ADDR_ARRAY_CONTROL, CTRL_RESET);
    rdc("unmapped", 8'h00, 8'h00);
    wait_wd(3200, c);
    chk("timeout", 8'(c + 8 >= 3068 && c + 8 <= 3090), 8'h01);
  endtask : t_defaults
  task automatic t_frozen();
    logic [7:0] v;
    do_reset(2);
    wr(ADDR_ARRAY_MODE, 8'hcf);
    rdc("mode frozen", ADDR_ARRAY_MODE, MODE_RESET);
    wr(ADDR_MODULE4_MODE, 8'h00);
    rdc("m4 mode", ADDR_MODULE4_MODE, M4_FORCED_MODE);
    wr(ADDR_ARRAY_CONTROL, 8'h00);
    wr(ADDR_COUNTER_HIGH, 8'h77);
    wr(ADDR_COUNTER_LOW, 8'h80);
    rdc("high", ADDR_COUNTER_HIGH, 8'h00);
    rdc("run bit", ADDR_ARRAY_CONTROL, 8'h00);
    repeat (40) @(negedge CLK);
    rd(ADDR_COUNTER_LOW, v);
    chk("running", 8'(v >= 8'h03 && v <= 8'h06), 8'h01);
  endtask : t_frozen
  task automatic t_lock();
    int c;
    do_reset(2);
    wr(ADDR_ARRAY_MODE, 8'h20);
    wr(ADDR_ARRAY_MODE, 8'h00);
    rdc("lock", ADDR_ARRAY_MODE, 8'h20);
    wr(ADDR_ARRAY_CONTROL, 8'h10);
    wait_wd(3, c);
    chk("forced", WD_RESET, 1'b1);
  endtask : t_lock
  task automatic t_reconfig();
    int c;
    do_reset(2);
    wr(ADDR_ARRAY_MODE, 8'h00);
    rdc("disabled", ADDR_ARRAY_MODE, 8'h00);
    wr(ADDR_COUNTER_LOW, 8'h00);
    wr(ADDR_COUNTER_HIGH, 8'h00);
    wr(ADDR_ARRAY_MODE, 8'h08);
    wr(ADDR_WD_OFFSET, 8'h01);
    wr(ADDR_ARRAY_MODE, 8'h48);
    wr(ADDR_WD_UPDATE, 8'h00);
    rdc("update byte", ADDR_WD_UPDATE, 8'h01);
    // Low byte is near zero at the update, so about 512 ticks of the system clock.
    wait_wd(600, c);
    chk("offset timeout", 8'(c >= 500 && c <= 520), 8'h01);
  endtask : t_reconfig
  task automatic t_flags();
    logic [7:0] a;
    logic [7:0] b;
    do_reset(2);
    wr(ADDR_ARRAY_MODE, 8'h09);
    wr(ADDR_ARRAY_MODE, 8'h09);
    wr(ADDR_COUNTER_LOW, 8'hf0);
    wr(ADDR_COUNTER_HIGH, 8'hff);
    wr(ADDR_ARRAY_CONTROL, 8'h60);
    repeat (20) @(negedge CLK);
    rdc("overflow", ADDR_ARRAY_CONTROL, 8'hc0);
    chk("irq", ARRAY_IRQ, 1'b1);
    wr(ADDR_ARRAY_CONTROL, 8'h00);
    rd(ADDR_COUNTER_LOW, a);
    rd(ADDR_COUNTER_LOW, b);
    chk("stopped", b, a);
    chk("irq off", ARRAY_IRQ, 1'b0);
    @(negedge CLK);
    MODULE_MATCH = 4'h5;
    @(negedge CLK);
    MODULE_MATCH = 4'h0;
    rdc("match", ADDR_ARRAY_CONTROL, 8'h05);
  endtask : t_flags
  task automatic t_idle_ce();
    logic [7:0] a;
    logic [7:0] b;
    do_reset(2);
    wr(ADDR_ARRAY_MODE, 8'h00);
    wr(ADDR_ARRAY_MODE, 8'h88);
    wr(ADDR_ARRAY_CONTROL, 8'h40);
    CPU_IDLE = 1'b1;
    rd(ADDR_COUNTER_LOW, a);
    rd(ADDR_COUNTER_LOW, b);
    chk("idle hold", b, a);
    CPU_IDLE = 1'b0;
    rd(ADDR_COUNTER_LOW, a);
    // Ten frozen edges out of twelve leave two counts between the reads.
    CE = 1'b0;
    repeat (10) @(negedge CLK);
    CE = 1'b1;
    rd(ADDR_COUNTER_LOW, b);
    chk("clock enable", b, a + 8'h02);
  endtask : t_idle_ce

  initial begin
    RST = 1'b1;
    SFR_WR = 1'b0;
    SFR_RD = 1'b0;
    SFR_ADDR = 8'h00;
    SFR_WDATA = 8'h00;
    MODULE_MATCH = 4'h0;
    CE = 1'b1;
    CPU_IDLE = 1'b0;
    miscompares = 0;
    checked = 0;
    t_defaults();
    t_frozen();
    t_lock();
    t_reconfig();
    t_flags();
    t_idle_ce();
    summarize();
  end
endmodule : testbench
